// >>> logic/tbtc_core.sv
// ten bit up/down timer with four compare registers and shared two bit upper buffer
// assumes processor strobes are one-cycle pulses on core_clk_i; pins are async
`include "tbtc_map.svh"

module tbtc_core import tbtc_pkg::*; #(
  parameter int PRESC_W = `TBTC_PRESC_W
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // processor register access
  input wire logic [2:0] reg_sel_i,
  input wire logic lo_wr_i,
  input wire logic lo_rd_i,
  input wire logic hi_wr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o,
  output logic [1:0] shared_upper_bits_buffer_o,
  // control
  input wire logic [3:0] clock_select_field_i,
  input wire logic fast_clock_enable_i,
  input wire logic low_speed_select_i,
  input wire logic waveform_mode_bit_i,
  input wire logic [2:0] channel_pwm_enable_i,
  input wire logic [5:0] compare_output_mode_i,
  input wire logic [2:0] force_match_strobe_i,
  // pins
  input wire logic fast_periph_clock_i,
  input wire logic fault_i,
  // flags and masks
  input wire logic [3:0] irq_mask_reg_i,
  input wire logic fault_protect_irq_mask_i,
  input wire logic [4:0] flag_clear_i,
  input wire logic [4:0] irq_service_i,
  output logic [4:0] irq_flag_reg_o,
  output logic [4:0] irq_req_o,
  // waveform and events
  output logic wave_out_a_o,
  output logic wave_out_b_o,
  output logic wave_out_d_o,
  output logic bottom_o,
  output logic top_o
);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // pin synchronisers
  logic fp_s1_q, fp_s2_q, fp_s3_q, half_q;
  logic fl_s1_q, fl_s2_q;
  logic fast_edge, base_tick, tick;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fp_s1_q <= 1'b0;
      fp_s2_q <= 1'b0;
      fp_s3_q <= 1'b0;
      fl_s1_q <= 1'b0;
      fl_s2_q <= 1'b0;
    end else begin
      fp_s1_q <= fast_periph_clock_i;
      fp_s2_q <= fp_s1_q;
      fp_s3_q <= fp_s2_q;
      fl_s1_q <= fault_i;
      fl_s2_q <= fl_s1_q;
    end
  end

  // fast clock seen as a sampled level: only usable while it is slow enough
  assign fast_edge = fp_s2_q && !fp_s3_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      half_q <= 1'b0;
    end else if (fast_edge) begin
      half_q <= ~half_q;
    end
  end

  // low speed passes every second fast edge
  assign base_tick = fast_clock_enable_i ?
                     (fast_edge && (!low_speed_select_i || half_q)) :
                     1'b1;

  tbtc_prescaler #(
    .PRESC_W(PRESC_W)
  ) u_presc (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .base_tick_i(base_tick),
    .clock_select_field_i(clock_select_field_i),
    .tick_o(tick)
  );

  // ==========================================================================
  // mode decode
  tbtc_mode_t mode;
  always_comb begin
    if (channel_pwm_enable_i == 3'h0) begin
      mode = TBTC_NORMAL;
    end else if (waveform_mode_bit_i) begin
      mode = TBTC_PFC_PWM;
    end else begin
      mode = TBTC_FAST_PWM;
    end
  end

  function automatic logic [1:0] slot_of(input logic [2:0] sel);
    slot_of = 2'(sel - 3'h1);
  endfunction : slot_of

  // ==========================================================================
  // compare registers: buf is what software sees, act is what compares
  tbtc_val_t cmp_buf_q [4];
  tbtc_val_t cmp_act_q [4];
  tbtc_val_t cnt_q, cnt_d;
  logic [1:0] hi_q;
  logic dir_q, dir_d, block_q, ovf_ev, buf_upd;
  logic cnt_wr, cmp_wr;
  logic [3:0] match;

  assign cnt_wr = lo_wr_i && (reg_sel_i == `TBTC_SEL_COUNT);
  assign cmp_wr = lo_wr_i && (reg_sel_i >= `TBTC_SEL_CMP_A) && (reg_sel_i <= `TBTC_SEL_CMP_D);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        cmp_buf_q[i] <= (i == `TBTC_IDX_TOP) ? `TBTC_TOP_RST : '0;
      end
    end else if (cmp_wr) begin
      cmp_buf_q[slot_of(reg_sel_i)] <= {hi_q, wr_data_i};
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        cmp_act_q[i] <= (i == `TBTC_IDX_TOP) ? `TBTC_TOP_RST : '0;
      end
    end else if (mode == TBTC_NORMAL) begin
      if (cmp_wr) begin
        cmp_act_q[slot_of(reg_sel_i)] <= {hi_q, wr_data_i};
      end
    end else if (buf_upd) begin
      for (int i = 0; i < 4; i++) begin
        cmp_act_q[i] <= cmp_buf_q[i];
      end
    end
  end

  // ==========================================================================
  // counter
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    ovf_ev = 1'b0;
    buf_upd = 1'b0;
    if (cnt_wr) begin
      cnt_d = {hi_q, wr_data_i};
    end else if (tick) begin
      unique case (mode)
        TBTC_NORMAL, TBTC_FAST_PWM: begin
          dir_d = 1'b0;
          if (cnt_q == cmp_act_q[`TBTC_IDX_TOP] || cnt_q == `TBTC_CNT_MAX) begin
            cnt_d = '0;
            ovf_ev = 1'b1;
            buf_upd = 1'b1;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        TBTC_PFC_PWM: begin
          if (!dir_q) begin
            if (cnt_q >= cmp_act_q[`TBTC_IDX_TOP] || cnt_q == `TBTC_CNT_MAX) begin
              dir_d = 1'b1;
              cnt_d = cnt_q - 1'b1;
            end else begin
              cnt_d = cnt_q + 1'b1;
            end
          end else if (cnt_q == '0) begin
            dir_d = 1'b0;
            cnt_d = cnt_q + 1'b1;
          end else begin
            cnt_d = cnt_q - 1'b1;
            ovf_ev = (cnt_d == '0);
            buf_upd = (cnt_d == '0);
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      dir_q <= 1'b0;
      bottom_o <= 1'b1;
      top_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      bottom_o <= (cnt_d == '0);
      top_o <= (cnt_d == cmp_act_q[`TBTC_IDX_TOP]);
    end
  end

  // ==========================================================================
  // match blocking after a counter write
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      block_q <= 1'b0;
    end else if (cnt_wr) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      match[i] = (cnt_q == cmp_act_q[i]) && !block_q;
    end
  end

  // ==========================================================================
  // flags: set wins over clear
  logic [4:0] flag_q, set_ev, clr_ev;
  assign set_ev[`TBTC_F_OVF] = ovf_ev;
  assign set_ev[`TBTC_F_A] = tick && !cnt_wr && match[`TBTC_IDX_A];
  assign set_ev[`TBTC_F_B] = tick && !cnt_wr && match[`TBTC_IDX_B];
  assign set_ev[`TBTC_F_D] = tick && !cnt_wr && match[`TBTC_IDX_D];
  assign set_ev[`TBTC_F_FP] = fl_s2_q;
  assign clr_ev = flag_clear_i | irq_service_i;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_q <= '0;
    end else begin
      flag_q <= set_ev | (flag_q & ~clr_ev);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_req_o <= '0;
    end else begin
      irq_req_o <= flag_q & {fault_protect_irq_mask_i, irq_mask_reg_i};
    end
  end

  // ==========================================================================
  // waveform generator
  function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                     input logic pwm, input logic hit, input logic up,
                                     input logic restart, input logic force_ev);
    logic lvl;
    lvl = (com == `TBTC_COM_SET);
    wave_next = cur;
    if (com == `TBTC_COM_NONE) begin
      wave_next = cur;
    end else if (!pwm) begin
      if (hit || force_ev) begin
        unique case (com)
          `TBTC_COM_TOGGLE: wave_next = ~cur;
          `TBTC_COM_CLEAR: wave_next = 1'b0;
          default: wave_next = 1'b1;
        endcase
      end
    end else if (hit) begin
      wave_next = up ? lvl : ~lvl;
    end else if (restart) begin
      wave_next = ~lvl;
    end
  endfunction : wave_next

  logic [2:0] wave_q;
  logic [1:0] ch_idx [3];
  assign ch_idx[0] = 2'(`TBTC_IDX_A);
  assign ch_idx[1] = 2'(`TBTC_IDX_B);
  assign ch_idx[2] = 2'(`TBTC_IDX_D);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wave_q <= '0;
    end else begin
      for (int c = 0; c < 3; c++) begin
        wave_q[c] <= wave_next(wave_q[c], compare_output_mode_i[2*c +: 2],
                               (mode != TBTC_NORMAL) && channel_pwm_enable_i[c],
                               tick && !cnt_wr && match[ch_idx[c]],
                               !(mode == TBTC_PFC_PWM && dir_q),
                               mode == TBTC_FAST_PWM && buf_upd,
                               force_match_strobe_i[c] && mode == TBTC_NORMAL);
      end
    end
  end

  assign wave_out_a_o = wave_q[0];
  assign wave_out_b_o = wave_q[1];
  assign wave_out_d_o = wave_q[2];

  // ==========================================================================
  // readback: count, buffer and flags lag two stages in fast clock mode
  tbtc_val_t cnt_p1_q, cnt_p2_q, rd_val;
  logic [4:0] flag_p1_q, flag_p2_q;
  logic [1:0] hi_p1_q, hi_p2_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_p1_q <= '0;
      cnt_p2_q <= '0;
      flag_p1_q <= '0;
      flag_p2_q <= '0;
      hi_p1_q <= '0;
      hi_p2_q <= '0;
    end else begin
      cnt_p1_q <= cnt_q;
      cnt_p2_q <= cnt_p1_q;
      flag_p1_q <= flag_q;
      flag_p2_q <= flag_p1_q;
      hi_p1_q <= hi_q;
      hi_p2_q <= hi_p1_q;
    end
  end

  always_comb begin
    if (reg_sel_i == `TBTC_SEL_COUNT) begin
      rd_val = fast_clock_enable_i ? cnt_p2_q : cnt_q;
    end else if (reg_sel_i <= `TBTC_SEL_CMP_D) begin
      rd_val = cmp_buf_q[slot_of(reg_sel_i)];
    end else begin
      rd_val = '0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_q <= '0;
    end else if (hi_wr_i) begin
      hi_q <= wr_data_i[1:0];
    end else if (lo_rd_i) begin
      hi_q <= rd_val[9:8];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
      shared_upper_bits_buffer_o <= '0;
      irq_flag_reg_o <= '0;
    end else begin
      if (lo_rd_i) begin
        rd_data_o <= rd_val[7:0];
      end
      shared_upper_bits_buffer_o <= fast_clock_enable_i ? hi_p2_q : hi_q;
      irq_flag_reg_o <= fast_clock_enable_i ? flag_p2_q : flag_q;
    end
  end

  // ==========================================================================
  // checks
  property p_write_wins;
    cnt_wr |=> cnt_q == {$past(hi_q), $past(wr_data_i)};
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("counter write lost against count or clear");

  property p_read_loads_hi;
    (lo_rd_i && !hi_wr_i) |=> hi_q == $past(rd_val[9:8]);
  endproperty
  a_read_loads_hi: assert property (p_read_loads_hi)
    else $error("low byte read did not load upper buffer");

  property p_cmp_readback;
    (lo_wr_i && reg_sel_i == `TBTC_SEL_CMP_A) ##1 (lo_rd_i && reg_sel_i == `TBTC_SEL_CMP_A)
      |=> rd_data_o == $past(wr_data_i, 2);
  endproperty
  a_cmp_readback: assert property (p_cmp_readback)
    else $error("compare readback not the value just written");

  property p_block_after_write;
    (block_q && tick && !cnt_wr && clr_ev[3:1] == 3'h0) |=> flag_q[3:1] == $past(flag_q[3:1]);
  endproperty
  a_block_after_write: assert property (p_block_after_write)
    else $error("match not blocked after counter write");

  property p_flag_on_match;
    (tick && !cnt_wr && match[`TBTC_IDX_A]) |=> flag_q[`TBTC_F_A];
  endproperty
  a_flag_on_match: assert property (p_flag_on_match)
    else $error("match a flag not set on tick");

  property p_clear_one;
    (flag_clear_i[`TBTC_F_B] && !set_ev[`TBTC_F_B]) |=> !flag_q[`TBTC_F_B];
  endproperty
  a_clear_one: assert property (p_clear_one)
    else $error("flag b not cleared by write of one");

  property p_bottom;
    bottom_o == (cnt_q == '0);
  endproperty
  a_bottom: assert property (p_bottom)
    else $error("bottom indication disagrees with count");

  property p_max_wrap;
    (tick && !cnt_wr && mode == TBTC_NORMAL && cnt_q == `TBTC_CNT_MAX) |=> cnt_q == '0;
  endproperty
  a_max_wrap: assert property (p_max_wrap)
    else $error("counter did not wrap at max");

  property p_normal_direct;
    (mode == TBTC_NORMAL && lo_wr_i && reg_sel_i == `TBTC_SEL_CMP_B)
      |=> cmp_act_q[`TBTC_IDX_B] == cmp_buf_q[`TBTC_IDX_B];
  endproperty
  a_normal_direct: assert property (p_normal_direct)
    else $error("normal mode compare write not direct");

  property p_force_clear;
    (mode == TBTC_NORMAL && force_match_strobe_i[0]
      && compare_output_mode_i[1:0] == `TBTC_COM_CLEAR) |=> !wave_q[0];
  endproperty
  a_force_clear: assert property (p_force_clear)
    else $error("force did not clear wave a");

endmodule : tbtc_core

// >>> logic/tbtc_map.svh
// constants of the ten bit timer compare core: selects, layouts, resets
// assumes inclusion by bare name from logic/ and verif/ files, with logic/ on the include path
`ifndef TBTC_MAP_SVH
`define TBTC_MAP_SVH

// ==========================================================================
// widths and resets
`define TBTC_CNT_W 10
`define TBTC_TOP_RST 10'h0ff
`define TBTC_CNT_MAX 10'h3ff
`define TBTC_PRESC_W 14

// ==========================================================================
// processor register selects
`define TBTC_SEL_COUNT 3'h0
`define TBTC_SEL_CMP_A 3'h1
`define TBTC_SEL_CMP_B 3'h2
`define TBTC_SEL_TOP 3'h3
`define TBTC_SEL_CMP_D 3'h4

// ==========================================================================
// compare register slots and flag positions
`define TBTC_IDX_A 0
`define TBTC_IDX_B 1
`define TBTC_IDX_TOP 2
`define TBTC_IDX_D 3
`define TBTC_F_OVF 0
`define TBTC_F_A 1
`define TBTC_F_B 2
`define TBTC_F_D 3
`define TBTC_F_FP 4

// ==========================================================================
// compare output mode codes
`define TBTC_COM_NONE 2'h0
`define TBTC_COM_TOGGLE 2'h1
`define TBTC_COM_CLEAR 2'h2
`define TBTC_COM_SET 2'h3

`endif

// >>> logic/tbtc_pkg.sv
// types of the ten bit timer compare core
// assumes nothing beyond a systemverilog compiler
package tbtc_pkg;

  // ========================================================================
  // counting sequence
  typedef enum logic [1:0] {
    TBTC_NORMAL = 2'b00,
    TBTC_FAST_PWM = 2'b01,
    TBTC_PFC_PWM = 2'b10
  } tbtc_mode_t;

  typedef logic [9:0] tbtc_val_t;

endpackage : tbtc_pkg

// >>> logic/tbtc_prescaler.sv
// prescaler: divides the selected base tick by a power of two
// assumes base_tick_i is a one-cycle enable on core_clk_i
`include "tbtc_map.svh"

module tbtc_prescaler import tbtc_pkg::*; #(
  parameter int PRESC_W = `TBTC_PRESC_W
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // control
  input wire logic base_tick_i,
  input wire logic [3:0] clock_select_field_i,
  // timer tick
  output logic tick_o
);

  // ========================================================================
  // divider
  logic [PRESC_W-1:0] div_q;
  logic [PRESC_W-1:0] mask;

  always_comb begin
    mask = '0;
    for (int i = 0; i < PRESC_W; i++) begin
      if (i < int'(clock_select_field_i) - 1) begin
        mask[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= '0;
    end else if (clock_select_field_i == 4'h0) begin
      div_q <= '0;
    end else if (base_tick_i) begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (clock_select_field_i != 4'h0) && base_tick_i
                && ((div_q & mask) == mask);
    end
  end

  // ========================================================================
  // checks
  property p_stopped_no_tick;
    @(posedge core_clk_i) disable iff (rst_i)
      (clock_select_field_i == 4'h0) |=> !tick_o;
  endproperty
  a_stopped_no_tick: assert property (p_stopped_no_tick)
    else $error("timer tick while clock select is zero");

endmodule : tbtc_prescaler

// >>> verif/tbtc_pll_model.sv
// model of the pll that feeds the fast peripheral clock pin
// assumes the bench enables it, waits out the lock time, then polls lock
// ==========================================================================
// pll model
module tbtc_pll_model #(
  parameter int HALF_NS = 50,
  parameter int LOCK_NS = 90000
) (
  // control
  input wire logic pll_enable_i,
  // clock and status
  output logic fast_periph_clock_o,
  output logic pll_lock_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // clock stands still until enabled; period kept above two core cycles
  initial begin
    fast_periph_clock_o = 1'b0;
    pll_lock_flag_o = 1'b0;
    wait (pll_enable_i === 1'b1);
    fork
      forever #HALF_NS fast_periph_clock_o = ~fast_periph_clock_o;
    join_none
    #LOCK_NS pll_lock_flag_o = 1'b1;
  end
endmodule : tbtc_pll_model

// >>> verif/ten_bit_timer_compare_core_bench.sv
// bench for the ten bit timer core: register tasks and checked sequences
// assumes logic/ on the include path and the pll model compiled before
`include "tbtc_map.svh"

module ten_bit_timer_compare_core_bench import tbtc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  // ========================================================================
  // signals
  logic clk, rst, lo_wr, lo_rd, hi_wr, fce, lss, wmb, fpc, fault, fmsk, pll_en, lock;
  logic wa, wb, wd, bot, top;
  logic [2:0] sel, pwm, foc;
  logic [7:0] wdata, rdata;
  logic [1:0] ubuf;
  logic [3:0] cs, msk;
  logic [5:0] com;
  logic [4:0] fclr, fsvc, flags, req;
  tbtc_val_t v, w;
  int err_total, checks_done, n;

  tbtc_core dut (.core_clk_i(clk), .rst_i(rst), .reg_sel_i(sel), .lo_wr_i(lo_wr),
    .lo_rd_i(lo_rd), .hi_wr_i(hi_wr), .wr_data_i(wdata), .rd_data_o(rdata),
    .shared_upper_bits_buffer_o(ubuf), .clock_select_field_i(cs),
    .fast_clock_enable_i(fce), .low_speed_select_i(lss), .waveform_mode_bit_i(wmb),
    .channel_pwm_enable_i(pwm), .compare_output_mode_i(com), .force_match_strobe_i(foc),
    .fast_periph_clock_i(fpc), .fault_i(fault), .irq_mask_reg_i(msk),
    .fault_protect_irq_mask_i(fmsk), .flag_clear_i(fclr), .irq_service_i(fsvc),
    .irq_flag_reg_o(flags), .irq_req_o(req), .wave_out_a_o(wa), .wave_out_b_o(wb),
    .wave_out_d_o(wd), .bottom_o(bot), .top_o(top));

  tbtc_pll_model pll (.pll_enable_i(pll_en), .fast_periph_clock_o(fpc),
    .pll_lock_flag_o(lock));

  // ========================================================================
  // tasks
  task automatic cyc(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({9'h000, got}, {9'h000, exp});
  endtask : chk_bit

  // upper bits go through the shared buffer first
  task automatic wr10(input logic [2:0] s, input logic [9:0] d);
    hi_wr = 1'b1;
    wdata = {6'h00, d[9:8]};
    cyc();
    hi_wr = 1'b0;
    lo_wr = 1'b1;
    sel = s;
    wdata = d[7:0];
    cyc();
    lo_wr = 1'b0;
  endtask : wr10

  // waits long enough for the slower fast-mode buffer view
  task automatic rd10(input logic [2:0] s, output logic [9:0] d);
    sel = s;
    lo_rd = 1'b1;
    cyc();
    lo_rd = 1'b0;
    cyc(4);
    d = {ubuf, rdata};
  endtask : rd10

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // ========================================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #500000;
    err_total++;
    end_sim();
  end

  // ========================================================================
  // sequence
  initial begin
    err_total = 0;
    checks_done = 0;
    rst = 1'b1;
    {lo_wr, lo_rd, hi_wr, fce, lss, wmb, fault, fmsk, pll_en} = '0;
    {sel, wdata, cs, pwm, com, foc, msk, fclr, fsvc} = '0;
    cyc(2);
    rst = 1'b0;
    chk_bit(bot, 1'b1);
    rd10(`TBTC_SEL_TOP, v);
    chk_val(v, `TBTC_TOP_RST);
    wr10(`TBTC_SEL_CMP_A, 10'h2a5);
    rd10(`TBTC_SEL_CMP_A, v);
    chk_val(v, 10'h2a5);
    // compare b and d slots, written directly in normal mode
    wr10(`TBTC_SEL_CMP_B, 10'h302);
    wr10(`TBTC_SEL_CMP_D, 10'h304);
    rd10(`TBTC_SEL_CMP_B, v);
    chk_val(v, 10'h302);
    rd10(`TBTC_SEL_CMP_D, v);
    chk_val(v, 10'h304);
    rd10(3'h5, v);
    chk_val({2'h0, v[7:0]}, 10'h000);
    // short period; counter preset equal to compare a must not match
    wr10(`TBTC_SEL_TOP, 10'h020);
    wr10(`TBTC_SEL_CMP_A, 10'h005);
    wr10(`TBTC_SEL_COUNT, 10'h005);
    msk = 4'hf;
    cs = 4'h1;
    cyc(8);
    chk_bit(flags[`TBTC_F_A], 1'b0);
    for (n = 0; n < 64 && flags[`TBTC_F_A] !== 1'b1; n++) cyc();
    chk_bit(flags[`TBTC_F_A], 1'b1);
    chk_bit(flags[`TBTC_F_OVF], 1'b1);
    cyc();
    chk_bit(req[`TBTC_F_A], 1'b1);
    fclr = 5'h02;
    fsvc = 5'h01;
    cyc();
    {fclr, fsvc} = '0;
    cyc();
    chk_val({8'h00, flags[1:0]}, 10'h000);
    // stopped counter holds its value and stays accessible
    cs = 4'h0;
    cyc(2);
    rd10(`TBTC_SEL_COUNT, v);
    cyc(10);
    rd10(`TBTC_SEL_COUNT, w);
    chk_val(w, v);
    wr10(`TBTC_SEL_COUNT, 10'h020);
    chk_bit(top, 1'b1);
    fclr = 5'h1f;
    cyc();
    fclr = 5'h00;
    // write lands on a running tick and must win
    cs = 4'h1;
    wr10(`TBTC_SEL_COUNT, 10'h3fe);
    for (n = 0; n < 6 && bot !== 1'b1; n++) cyc();
    chk_bit(bot, 1'b1);
    // flag view trails the flag by one register
    cyc();
    chk_bit(flags[`TBTC_F_OVF], 1'b1);
    cs = 4'h0;
    // force on all channels: set, clear, toggle, none
    for (n = 0; n < 4; n++) begin
      com = {3{2'(3 - n)}};
      foc = 3'b111;
      cyc();
      foc = 3'b000;
      cyc(2);
      chk_bit(wa, (n == 1) ? 1'b0 : 1'b1);
      chk_bit(wb, (n == 1) ? 1'b0 : 1'b1);
      chk_bit(wd, (n == 1) ? 1'b0 : 1'b1);
    end
    pwm = 3'b001;
    com = {4'h0, `TBTC_COM_CLEAR};
    foc = 3'b001;
    cyc();
    foc = 3'b000;
    cyc(2);
    chk_bit(wa, 1'b1);
    wr10(`TBTC_SEL_CMP_A, 10'h011);
    rd10(`TBTC_SEL_CMP_A, v);
    chk_val(v, 10'h011);
    // up/down count: wave follows match direction, compare a reloads at bottom
    wmb = 1'b1;
    wr10(`TBTC_SEL_COUNT, 10'h001);
    cs = 4'h1;
    cyc(20);
    chk_bit(wa, 1'b0);
    for (n = 0; n < 80 && bot !== 1'b1; n++) cyc();
    chk_bit(bot, 1'b1);
    chk_bit(wa, 1'b1);
    cyc(8);
    chk_bit(wa, 1'b1);
    cyc(12);
    chk_bit(wa, 1'b0);
    cs = 4'h0;
    wmb = 1'b0;
    pwm = 3'b000;
    fault = 1'b1;
    fmsk = 1'b1;
    cyc(5);
    fault = 1'b0;
    chk_bit(flags[`TBTC_F_FP], 1'b1);
    cyc();
    chk_bit(req[`TBTC_F_FP], 1'b1);
    // enable pll, wait, poll lock, then switch to the fast clock
    wr10(`TBTC_SEL_TOP, `TBTC_CNT_MAX);
    pll_en = 1'b1;
    cyc(2500);
    for (n = 0; n < 1000 && lock !== 1'b1; n++) cyc();
    chk_bit(lock, 1'b1);
    for (int k = 0; k < 2; k++) begin
      lss = k[0];
      fce = 1'b1;
      wr10(`TBTC_SEL_COUNT, 10'h000);
      cs = 4'h1;
      cyc(100);
      cs = 4'h0;
      rd10(`TBTC_SEL_COUNT, v);
      chk_bit(v >= (10'd32 >> k) && v <= (10'd48 >> k), 1'b1);
    end
    end_sim();
  end
endmodule : ten_bit_timer_compare_core_bench
